// [rbds_defs.svh]
`ifndef RBDS_DEFS_SVH
`define RBDS_DEFS_SVH
`define RBDS_CLK_HZ 10000000
`define RBDS_OPEN_MIN_MS 5
`define RBDS_OPEN_CYCLES ((`RBDS_CLK_HZ / 1000) * `RBDS_OPEN_MIN_MS)
`define RBDS_ADDR_W 3
`define RBDS_BANKS 3
`define RBDS_LINES_PER_BANK 24
`define RBDS_RESETS_PER_BANK 4
`define RBDS_SETTLE_W 24
`define RBDS_SETTLE_RST 24'h000001
`endif

// [rbds_pkg.sv]
package rbds_pkg;
  typedef enum logic {RBDS_MODE_CONT, RBDS_MODE_PULSE} rbds_mode_e;
  typedef enum {RBDS_IDLE, RBDS_RESET_PULSE, RBDS_DRIVE_PULSE} rbds_bank_state_e;
endpackage : rbds_pkg

// [rbds_bank.sv]
`include "rbds_defs.svh"
module rbds_bank
  import rbds_pkg::*;
#(
  parameter int LINES = `RBDS_LINES_PER_BANK,
  parameter int RESETS = `RBDS_RESETS_PER_BANK,
  parameter int SW = `RBDS_SETTLE_W
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [LINES-1:0] cmd_lines,
  input wire logic cmd_need_reset,
  input wire logic pulse_mode,
  input wire logic [SW-1:0] settle_cycles,
  input wire logic force_open,
  output logic [LINES-1:0] coil_sink_line,
  output logic [RESETS-1:0] reset_line,
  output logic busy
);
  rbds_bank_state_e state, next_state;
  logic [SW-1:0] timer, next_timer;
  logic [LINES-1:0] pend, next_pend;
  logic [LINES-1:0] next_coil;
  logic [RESETS-1:0] next_reset;
  logic [SW-1:0] width;

  always_comb begin
    width = (settle_cycles == '0) ? SW'(1) : settle_cycles;
    next_state = state;
    next_timer = timer;
    next_pend = pend;
    next_coil = coil_sink_line;
    next_reset = reset_line;
    if (force_open) begin
      next_state = RBDS_IDLE;
      next_coil = '0;
      next_reset = '0;
      next_timer = '0;
    end else begin
      case (state)
        RBDS_IDLE: begin
          if (cmd_valid) begin
            if (!pulse_mode) begin
              next_coil = cmd_lines;
            end else if (cmd_need_reset) begin
              next_pend = cmd_lines;
              next_reset = '1;
              next_timer = width;
              next_state = RBDS_RESET_PULSE;
            end else begin
              next_coil = cmd_lines;
              next_timer = width;
              next_state = RBDS_DRIVE_PULSE;
            end
          end
        end
        RBDS_RESET_PULSE: begin
          next_timer = timer - SW'(1);
          if (timer == SW'(1)) begin
            next_reset = '0;
            next_coil = pend;
            next_timer = width;
            next_state = RBDS_DRIVE_PULSE;
          end
        end
        RBDS_DRIVE_PULSE: begin
          next_timer = timer - SW'(1);
          if (timer == SW'(1)) begin
            next_coil = '0;
            next_state = RBDS_IDLE;
          end
        end
        default: next_state = RBDS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= RBDS_IDLE;
      timer <= '0;
      pend <= '0;
      coil_sink_line <= '0;
      reset_line <= '0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      timer <= next_timer;
      pend <= next_pend;
      coil_sink_line <= next_coil;
      reset_line <= next_reset;
      busy <= (next_state != RBDS_IDLE);
    end
  end
endmodule : rbds_bank

// [rbds_top.sv]
`include "rbds_defs.svh"
module rbds_top
  import rbds_pkg::*;
#(
  parameter int BANKS = `RBDS_BANKS,
  parameter int LINES = `RBDS_LINES_PER_BANK,
  parameter int RESETS = `RBDS_RESETS_PER_BANK,
  parameter int SW = `RBDS_SETTLE_W,
  parameter int AW = `RBDS_ADDR_W,
  parameter int OPEN_CYCLES = `RBDS_OPEN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [AW-1:0] board_addr_switch,
  input wire logic cmd_valid,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [BANKS-1:0] cmd_bank_sel,
  input wire logic [LINES-1:0] cmd_lines,
  input wire logic cmd_need_reset,
  input wire logic settle_wr,
  input wire logic [SW-1:0] settle_wdata,
  input wire logic [BANKS-1:0] bank_pulse_mode,
  input wire logic soft_reset,
  input wire logic panel_open_n,
  input wire logic panel_accept,
  input wire logic system_open_in,
  output logic [BANKS*LINES-1:0] coil_sink_line,
  output logic [BANKS*RESETS-1:0] reset_line,
  output logic [BANKS-1:0] bank_busy,
  output logic [SW-1:0] settle_time,
  output logic system_open_out,
  output logic monitor_error
);
  logic [1:0] pin_sync, next_pin_sync;
  logic [1:0] sys_sync, next_sys_sync;
  logic [AW-1:0] addr_meta, next_addr_meta;
  logic [AW-1:0] addr_sync, next_addr_sync;
  logic [1:0] fill, next_fill;
  logic [31:0] low_cnt, next_low_cnt;
  logic open_latched, next_open_latched;
  logic [SW-1:0] next_settle;
  logic [AW-1:0] my_addr, next_my_addr;
  logic addr_caught, next_addr_caught;
  logic panel_active, force_open, cmd_ok;
  logic next_sys_out, next_mon;

  function automatic logic addr_match(input logic [AW-1:0] a, input logic [AW-1:0] b);
    addr_match = (a == b);
  endfunction : addr_match

  // pins and the other boards' open line cross into core_clk through two flops;
  // the rotary switch is static, so a per-bit synchroniser is enough for it
  always_comb begin
    next_pin_sync = {pin_sync[0], ~panel_open_n};
    next_sys_sync = {sys_sync[0], system_open_in};
    next_addr_meta = board_addr_switch;
    next_addr_sync = addr_meta;
    next_fill = {fill[0], 1'b1};
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_sync <= 2'h0;
      sys_sync <= 2'h0;
      addr_meta <= '0;
      addr_sync <= '0;
      fill <= 2'h0;
    end else begin
      pin_sync <= next_pin_sync;
      sys_sync <= next_sys_sync;
      addr_meta <= next_addr_meta;
      addr_sync <= next_addr_sync;
      fill <= next_fill;
    end
  end

  // open detection: set wins over a soft reset in the same cycle
  always_comb begin
    panel_active = panel_accept & pin_sync[1];
    next_low_cnt = panel_active ? low_cnt + ((low_cnt < OPEN_CYCLES) ? 32'h1 : 32'h0) : 32'h0;
    next_open_latched = open_latched;
    if ((panel_active && low_cnt >= OPEN_CYCLES - 1) || sys_sync[1]) begin
      next_open_latched = 1'b1;
    end else if (soft_reset && !panel_active && !sys_sync[1]) begin
      next_open_latched = 1'b0;
    end
    next_sys_out = next_open_latched;
    next_mon = next_open_latched | panel_active;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 32'h0;
      open_latched <= 1'b0;
      system_open_out <= 1'b0;
      monitor_error <= 1'b0;
    end else begin
      low_cnt <= next_low_cnt;
      open_latched <= next_open_latched;
      system_open_out <= next_sys_out;
      monitor_error <= next_mon;
    end
  end

  always_comb begin
    next_settle = settle_wr ? settle_wdata : settle_time;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      settle_time <= SW'(`RBDS_SETTLE_RST);
    end else begin
      settle_time <= next_settle;
    end
  end

  // address caught once, after the synchroniser has filled;
  // a switch turned in service takes effect only at the next reset
  always_comb begin
    next_my_addr = my_addr;
    next_addr_caught = addr_caught;
    if (!addr_caught && fill[1]) begin
      next_my_addr = addr_sync;
      next_addr_caught = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      my_addr <= '0;
      addr_caught <= 1'b0;
    end else begin
      my_addr <= next_my_addr;
      addr_caught <= next_addr_caught;
    end
  end

  // commands before the address is caught are dropped, not queued
  always_comb begin
    force_open = open_latched;
    cmd_ok = cmd_valid && addr_caught && addr_match(cmd_addr, my_addr)
             && !open_latched && !panel_active;
  end

  // each bank keeps its own mode and sequencer so banks never mix
  genvar g;
  generate
    for (g = 0; g < BANKS; g++) begin : g_bank
      rbds_bank #(.LINES(LINES), .RESETS(RESETS), .SW(SW)) u_bank (
        .core_clk(core_clk),
        .rst(rst),
        .cmd_valid(cmd_ok & cmd_bank_sel[g]),
        .cmd_lines(cmd_lines),
        .cmd_need_reset(cmd_need_reset),
        .pulse_mode(bank_pulse_mode[g]),
        .settle_cycles(settle_time),
        .force_open(force_open),
        .coil_sink_line(coil_sink_line[g*LINES +: LINES]),
        .reset_line(reset_line[g*RESETS +: RESETS]),
        .busy(bank_busy[g])
      );
    end
  endgenerate
endmodule : rbds_top

// [rbds_chk.sv]
module rbds_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] board_addr_switch,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_addr,
  input wire logic [2:0] cmd_bank_sel,
  input wire logic [23:0] cmd_lines,
  input wire logic settle_wr,
  input wire logic [23:0] settle_wdata,
  input wire logic [2:0] bank_pulse_mode,
  input wire logic soft_reset,
  input wire logic panel_open_n,
  input wire logic [71:0] coil_sink_line,
  input wire logic [11:0] reset_line,
  input wire logic [2:0] bank_busy,
  input wire logic [23:0] settle_time,
  input wire logic system_open_out,
  input wire logic monitor_error
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // the board needs a few cycles after reset to catch its address
  logic [1:0] ready_cnt;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ready_cnt <= 2'h0;
    end else if (ready_cnt != 2'h3) begin
      ready_cnt <= ready_cnt + 2'h1;
    end
  end
  sequence s_mine;
    cmd_valid && cmd_addr == board_addr_switch && !monitor_error && panel_open_n
      && ready_cnt == 2'h3;
  endsequence
  property p_open;
    system_open_out |=> coil_sink_line == 72'h0 && reset_line == 12'h0;
  endproperty
  property p_keep;
    !(cmd_valid && cmd_addr == board_addr_switch) && !bank_pulse_mode[0]
      |=> $stable(coil_sink_line[23:0]) || monitor_error;
  endproperty
  property p_cont;
    s_mine ##0 (cmd_bank_sel[0] && !bank_pulse_mode[0]) |=> coil_sink_line[23:0] == $past(cmd_lines);
  endproperty
  property p_start;
    s_mine ##0 (cmd_bank_sel[1] && bank_pulse_mode[1] && !bank_busy[1]) |=> bank_busy[1];
  endproperty
  property p_end;
    bank_pulse_mode[1] && $fell(bank_busy[1]) |-> coil_sink_line[47:24] == 24'h0;
  endproperty
  property p_rfirst;
    reset_line[7:4] != 4'h0 |-> coil_sink_line[47:24] == 24'h0;
  endproperty
  property p_settle;
    settle_wr && settle_wdata != 24'h0 |=> settle_time == $past(settle_wdata);
  endproperty
  property p_latch;
    system_open_out && !soft_reset |=> system_open_out;
  endproperty
  a_open: assert property (p_open) else $error("open not forced");
  a_keep: assert property (p_keep) else $error("held state moved");
  a_cont: assert property (p_cont) else $error("bank not updated");
  a_start: assert property (p_start) else $error("pulse not started");
  a_end: assert property (p_end) else $error("drive left on");
  a_rfirst: assert property (p_rfirst) else $error("reset overlaps drive");
  a_settle: assert property (p_settle) else $error("settle not stored");
  a_latch: assert property (p_latch) else $error("open latch lost");
endmodule : rbds_chk

bind rbds_top rbds_chk u_chk (.core_clk, .rst, .board_addr_switch, .cmd_valid, .cmd_addr,
  .cmd_bank_sel, .cmd_lines, .settle_wr, .settle_wdata, .bank_pulse_mode, .soft_reset,
  .panel_open_n, .coil_sink_line, .reset_line, .bank_busy, .settle_time, .system_open_out,
  .monitor_error);

// [rbds_host.sv]
module rbds_host (
  input wire logic core_clk,
  output logic cmd_valid = 1'b0,
  output logic [2:0] cmd_addr = 3'h0,
  output logic [2:0] cmd_bank_sel = 3'h0,
  output logic [23:0] cmd_lines = 24'h0,
  output logic cmd_need_reset = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // callers wait out settling before trusting the state
  task send(input logic [2:0] a, input logic [2:0] b, input logic [23:0] d, input logic r);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_addr <= a;
    cmd_bank_sel <= b;
    cmd_lines <= d;
    cmd_need_reset <= r;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    // stale pattern inverted so a late read cannot pass
    cmd_lines <= ~d;
  endtask : send
endmodule : rbds_host

// [test_rbds_top.sv]
module test_rbds_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic settle_wr = 1'b0;
  logic soft_reset = 1'b0;
  logic panel_open_n = 1'b1;
  logic cmd_valid, cmd_need_reset, err, sys_out;
  logic [2:0] cmd_addr, cmd_bank_sel;
  logic [23:0] cmd_lines, st;
  logic [71:0] coil;
  logic [2:0] busy;
  logic sys_in = 1'b0;
  logic [11:0] rl;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  always #50 core_clk = ~core_clk;
  rbds_host host (.core_clk, .cmd_valid, .cmd_addr, .cmd_bank_sel, .cmd_lines, .cmd_need_reset);
  rbds_top #(.OPEN_CYCLES(8)) dut (.core_clk, .rst, .board_addr_switch(3'h5), .cmd_valid,
    .cmd_addr, .cmd_bank_sel, .cmd_lines, .cmd_need_reset, .settle_wr,
    .settle_wdata(24'h000003), .bank_pulse_mode(3'h2), .soft_reset, .panel_open_n,
    .panel_accept(1'b1), .system_open_in(sys_in), .coil_sink_line(coil), .reset_line(rl),
    .bank_busy(busy), .settle_time(st), .system_open_out(sys_out), .monitor_error(err));
  task chk(input string n, input logic [71:0] s, input logic [71:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick
  task close_out;
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    tick(2);
    chk("coil", coil, 72'h0);
    chk("rst", 72'(rl), 72'h0);
    chk("busy", 72'(busy), 72'h0);
    chk("settle", 72'(st), 72'h1);
    @(posedge core_clk);
    settle_wr <= 1'b1;
    @(posedge core_clk);
    settle_wr <= 1'b0;
    tick(1);
    chk("settle", 72'(st), 72'h3);
    host.send(3'h5, 3'h1, 24'hA5A5A5, 1'b0);
    tick(0);
    chk("coil", coil, 72'hA5A5A5);
    host.send(3'h2, 3'h1, 24'h0F0F0F, 1'b0);
    tick(2);
    chk("coil", coil, 72'hA5A5A5);
    host.send(3'h5, 3'h5, 24'h123456, 1'b0);
    tick(0);
    chk("coil", coil, {24'h123456, 24'h0, 24'h123456});
    host.send(3'h5, 3'h2, 24'hFFFFFF, 1'b1);
    tick(0);
    chk("rst", 72'(rl), 72'h0F0);
    chk("busy", 72'(busy), 72'h2);
    chk("coil", coil, {24'h123456, 24'h0, 24'h123456});
    tick(3);
    chk("coil", coil, {72'h123456FFFFFF123456});
    chk("rst", 72'(rl), 72'h0);
    tick(3);
    chk("coil", coil, {24'h123456, 24'h0, 24'h123456});
    chk("busy", 72'(busy), 72'h0);
    host.send(3'h5, 3'h2, 24'h00FF00, 1'b0);
    tick(0);
    chk("coil", coil, {24'h123456, 24'h00FF00, 24'h123456});
    tick(3);
    chk("coil", coil, {24'h123456, 24'h0, 24'h123456});
    @(posedge core_clk);
    panel_open_n <= 1'b0;
    tick(16);
    chk("err", 72'(err), 72'h1);
    chk("sys", 72'(sys_out), 72'h1);
    chk("coil", coil, 72'h0);
    host.send(3'h5, 3'h1, 24'hFFFFFF, 1'b0);
    tick(1);
    chk("coil", coil, 72'h0);
    @(posedge core_clk);
    panel_open_n <= 1'b1;
    tick(6);
    chk("err", 72'(err), 72'h1);
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    tick(2);
    chk("err", 72'(err), 72'h0);
    host.send(3'h5, 3'h1, 24'h3C3C3C, 1'b0);
    tick(0);
    chk("coil", coil, 72'h3C3C3C);
    @(posedge core_clk);
    sys_in <= 1'b1;
    tick(5);
    chk("coil", coil, 72'h0);
    chk("err", 72'(err), 72'h1);
    chk("sys", 72'(sys_out), 72'h1);
    @(posedge core_clk);
    sys_in <= 1'b0;
    tick(3);
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    tick(2);
    chk("err", 72'(err), 72'h0);
    chk("sys", 72'(sys_out), 72'h0);
    close_out();
  end
endmodule : test_rbds_top
